// ===== tb/jasc_far_side.sv
`timescale 1ns/1ps
// ============================================================================
// Operator switches, analog source and a motor that reports standstill
// ============================================================================
module jasc_far_side (
  input  wire logic               i_mclk,
  input  wire logic signed [15:0] i_speed,
  output logic             [3:0]  o_pins,
  output logic                    o_standstill,
  output logic                    o_fault,
  output logic                    o_amp_en,
  output logic                    o_dev_active,
  output logic signed      [15:0] o_dev_value,
  output logic signed      [11:0] o_adc
);
  import jasc_pkg::*;

  // Everything starts idle: manual mode selected, no jog; the device word comes from set_io.
  initial begin
    o_pins = 4'h0;
    o_fault = 1'b0;
    o_amp_en = 1'b0;
    o_dev_active = 1'b0;
    o_adc = 12'sh000;
  end

  // The motor is only at rest once a zero command has been seen for a full cycle.
  always @(posedge i_mclk) begin
    o_standstill <= (i_speed == 16'sh0000);
  end

  // Switch levels change only just after an edge; low selects manual mode.
  task automatic set_pins(input logic [3:0] v);
    @(posedge i_mclk);
    o_pins <= v;
  endtask

  // Fault, amplifier, input device and analog word move together.
  task automatic set_io(input logic f, a, d, input logic signed [15:0] dv, input logic signed [11:0] ad);
    @(posedge i_mclk);
    o_fault <= f;
    o_amp_en <= a;
    o_dev_active <= d;
    o_dev_value <= dv;
    o_adc <= ad;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
// ============================================================================
// Self-checking bench for the jog and analog setpoint block
// ============================================================================
module tb;
  import jasc_pkg::*;
  logic               i_mclk;
  logic               i_rst_b;
  jasc_bus_t          i_bus;
  logic        [15:0] o_rdata;
  logic        [3:0]  pins;
  logic               stand;
  logic               fault;
  logic               amp;
  logic               dev;
  logic signed [15:0] devv;
  logic signed [11:0] adc;
  jasc_cmd_t          o_cmd;
  jasc_state_t        o_state;
  int                 mismatches;
  int                 tests_run;
  int                 n;
  int                 adcs [4] = '{2047, -1024, 0, -2048};

  jasc_top dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_bus(i_bus), .o_rdata(o_rdata), .i_pins(pins),
                .i_standstill(stand), .i_fault(fault), .i_amp_en(amp), .i_dev_active(dev),
                .i_dev_value(devv), .i_adc(adc), .o_cmd(o_cmd), .o_state(o_state));
  jasc_far_side far (.i_mclk(i_mclk), .i_speed(o_cmd.speed), .o_pins(pins), .o_standstill(stand),
                     .o_fault(fault), .o_amp_en(amp), .o_dev_active(dev), .o_dev_value(devv), .o_adc(adc));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic check(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One-cycle write strobe; the slave never stalls.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_mclk);
    i_bus.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_mclk);
    i_bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_mclk);
    i_bus.rd <= 1'b0;
    #1;
    check(nm, o_rdata, exp);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask

  // Bounded wait for a state; the cycle count is kept for the stop-length check.
  task automatic wait_st(input jasc_state_t s);
    n = 0;
    while (o_state !== s && n < 400) begin
      settle(1);
      n++;
    end
    check("state", 16'(o_state), 16'(s));
  endtask

  // Truncation toward zero matches the integer division of the scaler.
  function automatic logic [15:0] scl(input int a, fs, lim);
    int v;
    v = a * fs / 2047;
    if (v > lim)
      v = lim;
    if (v < -lim)
      v = -lim;
    return 16'(v);
  endfunction

  // Jog with pins and software bits, then return to manual standby.
  task automatic jog(input logic [3:0] p, c, input logic [15:0] sp, il);
    far.set_pins(p);
    wr(A_CTRL, {12'h000, c});
    wait_st(JASC_JOG);
    settle(2);
    check("jog_speed", o_cmd.speed, sp);
    check("jog_ilim", o_cmd.ilim, il);
    check("jog_kind", {14'h0000, o_cmd.speed_ctrl, o_cmd.current_ctrl}, 16'h0002);
    far.set_pins(4'h0);
    wr(A_CTRL, 16'h0000);
    wait_st(JASC_MAN);
  endtask

  task automatic auto_chk(input int lim);
    foreach (adcs[i]) begin
      far.set_io(1'b0, 1'b1, 1'b0, 16'sh0000, 12'(adcs[i]));
      settle(2);
      check("auto_speed", o_cmd.speed, scl(adcs[i], 3000, lim));
    end
  endtask

  task automatic results();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and test sequence
  // ==========================================================================
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // The whole sequence needs a few hundred cycles; this limit leaves ample slack.
  initial begin
    repeat (20000) @(posedge i_mclk);
    mismatches++;
    $display("watchdog expired");
    results();
  end

  initial begin
    i_rst_b = 1'b0;
    i_bus = '0;
    mismatches = 0;
    tests_run = 0;
    far.set_io(1'b0, 1'b0, 1'b0, 16'sh0000, 12'sh000);
    repeat (19) @(posedge i_mclk);
    check("state_rst", 16'(o_state), 16'(JASC_STOP));
    i_rst_b <= 1'b1;
    rd_chk("ctrl", A_CTRL, 16'(RST_CTRL));
    for (int i = 0; i < 10; i++)
      rd_chk("cfg", 4'(i + 1), CFG_RST[159 - 16 * i -: 16]);
    rd_chk("unmapped", 4'hC, 16'h0000);
    $display("test reset values done");

    wait_st(JASC_MAN);
    rd_chk("status", A_STATUS, 16'h0012);
    far.set_io(1'b0, 1'b1, 1'b0, 16'sh0000, 12'sd2047);
    settle(5);
    check("man_speed", o_cmd.speed, 16'h0000);
    check("man_cur", {15'h0000, o_cmd.current_ctrl}, 16'h0000);
    $display("test manual standby done");

    jog(4'h4, 4'h0, RST_JOG_SLOW, RST_JOG_ILIM);
    jog(4'hA, 4'h0, -RST_JOG_FAST, RST_JOG_ILIM);
    jog(4'h0, 4'h1, RST_JOG_SLOW, RST_JOG_ILIM);
    jog(4'h0, 4'h6, -RST_JOG_FAST, RST_JOG_ILIM);
    // Start a real jog, then add the opposing request while it runs.
    far.set_pins(4'h4);
    wait_st(JASC_JOG);
    far.set_pins(4'h6);
    wait_st(JASC_MAN);
    check("both_dirs", o_cmd.speed, 16'h0000);
    far.set_pins(4'h0);
    wait_st(JASC_MAN);
    far.set_io(1'b1, 1'b1, 1'b0, 16'sh0000, 12'sh000);
    far.set_pins(4'h4);
    settle(8);
    check("fault_block", 16'(o_state), 16'(JASC_MAN));
    far.set_pins(4'h0);
    // The synchronised request must be gone before the fault clears, or a stray jog starts.
    settle(2);
    far.set_io(1'b0, 1'b1, 1'b0, 16'sh0000, 12'sh000);
    wr(A_JOG_SLOW, 16'h1B58);
    wr(A_MOT_IPK, 16'h0190);
    wr(A_JOG_ILIM, 16'h0320);
    jog(4'h4, 4'h0, RST_TOP_SPD, 16'h0190);
    $display("test jogging done");

    far.set_pins(4'h1);
    wait_st(JASC_STOP);
    wait_st(JASC_AUTO);
    check("stop_len", 16'(n), 16'(STOP_CYCLES));
    auto_chk(6000);
    wr(A_SPD_LIM, 16'h07D0);
    auto_chk(2000);
    far.set_io(1'b0, 1'b0, 1'b0, 16'sh0000, 12'sd2047);
    settle(2);
    check("amp_off", o_cmd.speed, 16'h0000);
    far.set_io(1'b0, 1'b1, 1'b1, 16'sd1234, 12'sd2047);
    settle(2);
    check("dev_value", o_cmd.speed, 16'h04D2);
    far.set_io(1'b0, 1'b1, 1'b0, 16'sh0000, 12'sd2047);
    wr(A_CTRL, 16'h0008);
    settle(2);
    check("cur_kind", {14'h0000, o_cmd.speed_ctrl, o_cmd.current_ctrl}, 16'h0001);
    check("cur_value", o_cmd.current, scl(2047, 300, 400));
    check("cur_ilim", o_cmd.ilim, 16'h0190);
    $display("test automatic mode done");

    wr(A_CTRL, 16'h0000);
    far.set_pins(4'h0);
    wait_st(JASC_STOP);
    wait_st(JASC_MAN);
    check("back_speed", o_cmd.speed, 16'h0000);
    $display("test return to manual done");
    results();
  end
endmodule

// ===== verilog/jasc_pkg.sv
package jasc_pkg;

  // ==========================================================================
  // Timing and conversion
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int STOP_TIME_NS  = 1000;
  localparam int STOP_CYCLES   = (STOP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADC_FULL      = 2047;

  // ==========================================================================
  // Register word addresses
  // ==========================================================================
  localparam logic [3:0] A_CTRL     = 4'h0;
  localparam logic [3:0] A_JOG_SLOW = 4'h1;
  localparam logic [3:0] A_JOG_FAST = 4'h2;
  localparam logic [3:0] A_JOG_ILIM = 4'h3;
  localparam logic [3:0] A_MOT_IPK  = 4'h4;
  localparam logic [3:0] A_AMP_IPK  = 4'h5;
  localparam logic [3:0] A_TOP_SPD  = 4'h6;
  localparam logic [3:0] A_SPD_FS   = 4'h7;
  localparam logic [3:0] A_CUR_FS   = 4'h8;
  localparam logic [3:0] A_SPD_LIM  = 4'h9;
  localparam logic [3:0] A_CUR_LIM  = 4'hA;
  localparam logic [3:0] A_STATUS   = 4'hB;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRL_JOG_CW   = 0;
  localparam int CTRL_JOG_CCW  = 1;
  localparam int CTRL_JOG_FAST = 2;
  localparam int CTRL_AUTO_CUR = 3;
  localparam int PIN_AUTO      = 0;
  localparam int PIN_CCW       = 1;
  localparam int PIN_CW        = 2;
  localparam int PIN_FAST      = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [3:0]  RST_CTRL     = 4'h0;
  localparam logic [15:0] RST_JOG_SLOW = 16'h0064;
  localparam logic [15:0] RST_JOG_FAST = 16'h01F4;
  localparam logic [15:0] RST_JOG_ILIM = 16'h0064;
  localparam logic [15:0] RST_MOT_IPK  = 16'h03E8;
  localparam logic [15:0] RST_AMP_IPK  = 16'h03E8;
  localparam logic [15:0] RST_TOP_SPD  = 16'h1770;
  localparam logic [15:0] RST_SPD_FS   = 16'h0BB8;
  localparam logic [15:0] RST_CUR_FS   = 16'h012C;
  localparam logic [15:0] RST_SPD_LIM  = 16'h1770;
  localparam logic [15:0] RST_CUR_LIM  = 16'h03E8;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [3:0] {
    JASC_STOP = 4'b0001,
    JASC_MAN  = 4'b0010,
    JASC_JOG  = 4'b0100,
    JASC_AUTO = 4'b1000
  } jasc_state_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } jasc_bus_t;

  typedef struct packed {
    logic               speed_ctrl;
    logic               current_ctrl;
    logic signed [15:0] speed;
    logic signed [15:0] current;
    logic [15:0]        ilim;
  } jasc_cmd_t;

  typedef struct packed {
    logic [15:0] jog_slow;
    logic [15:0] jog_fast;
    logic [15:0] jog_ilim;
    logic [15:0] mot_ipk;
    logic [15:0] amp_ipk;
    logic [15:0] top_spd;
    logic [15:0] spd_fs;
    logic [15:0] cur_fs;
    logic [15:0] spd_lim;
    logic [15:0] cur_lim;
  } jasc_cfg_t;

  localparam jasc_cfg_t CFG_RST = '{RST_JOG_SLOW, RST_JOG_FAST, RST_JOG_ILIM, RST_MOT_IPK, RST_AMP_IPK,
                                    RST_TOP_SPD, RST_SPD_FS, RST_CUR_FS, RST_SPD_LIM, RST_CUR_LIM};

  // ==========================================================================
  // Shared arithmetic
  // ==========================================================================
  // Smaller of two unsigned magnitudes.
  function automatic logic [15:0] min_u(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  // Sign extension to the working width.
  function automatic logic signed [17:0] sx(input logic signed [15:0] v);
    return {{2{v[15]}}, v};
  endfunction

  // Clamps to plus or minus a magnitude; the magnitude saturates at the signed range.
  function automatic logic signed [15:0] clamp_s(input logic signed [17:0] v, input logic [15:0] lim);
    logic signed [17:0] l;
    logic signed [17:0] n;
    l = $signed({3'b000, (lim[15] ? 15'h7FFF : lim[14:0])});
    n = -l;
    if (v > l) begin
      return l[15:0];
    end else if (v < n) begin
      return n[15:0];
    end
    return v[15:0];
  endfunction

endpackage

// ===== verilog/jasc_scale.sv
`timescale 1ns/1ps
module jasc_scale (
  input  wire logic signed [11:0] i_sample,
  input  wire logic        [15:0] i_full,
  input  wire logic        [15:0] i_lim,
  output logic signed      [15:0] o_value
);
  import jasc_pkg::*;

  localparam logic signed [28:0] DIV = 29'(ADC_FULL);

  logic signed [28:0] prod;
  logic signed [28:0] quo;

  // ==========================================================================
  // Proportional scaling
  // ==========================================================================
  // A true divide keeps the full-scale code exact; a shift would lose counts at the top, two at the reset speed full scale of 3000.
  always_comb begin
    prod    = i_sample * $signed({1'b0, i_full});
    quo     = prod / DIV;
    o_value = clamp_s(quo[17:0], i_lim);
  end

endmodule

// ===== verilog/jasc_top.sv
`timescale 1ns/1ps
// Behaviour
// - Manual jog mode always runs the motor under speed control.
// - Exactly two jog speeds, commanded by software, handheld unit or jog pins.
// - Counter-clockwise jog request moves the motor counter-clockwise; a negative jog speed setting runs it clockwise instead.
// - Clockwise jog request moves the motor clockwise; a negative jog speed setting runs it counter-clockwise instead.
// - Speed select high picks the fast jog speed, low picks slow.
// - Jog speeds are signed and bounded by the motor top speed.
// - Jogging limits current to the jog limit, at most the maximum current.
// - Maximum current is the smaller of motor and amplifier peak currents.
// - Analog speed or current control only in automatic operation.
// - Analog setpoint sampled every clock with 12-bit resolution.
// - Enabled amplifier follows scaled analog at once, or an active input device.
// - Automatic speed and current commands are clamped by the two configured limits; jog speeds only by the top speed.
// - Target speed is proportional to the input, full scale at 10 V.
// - Speed full scale resets to 3000 rpm, range zero to top speed.
// - A jog starts only at standstill with no fault present.
// - Changing between manual and automatic stops briefly, then loads the new mode.
module jasc_top (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_b,
  input  wire jasc_pkg::jasc_bus_t   i_bus,
  output logic [15:0]                o_rdata,
  input  wire logic [3:0]            i_pins,
  input  wire logic                  i_standstill,
  input  wire logic                  i_fault,
  input  wire logic                  i_amp_en,
  input  wire logic                  i_dev_active,
  input  wire logic signed [15:0]    i_dev_value,
  input  wire logic signed [11:0]    i_adc,
  output jasc_pkg::jasc_cmd_t        o_cmd,
  output jasc_pkg::jasc_state_t      o_state
);
  import jasc_pkg::*;

  localparam logic [7:0] STOP_LOAD = 8'(STOP_CYCLES - 1);

  typedef struct packed {
    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic [3:0]  ctrl;
    jasc_cfg_t   cfg;
    jasc_state_t state;
    logic [7:0]  stop_cnt;
    logic [15:0] rdata;
    jasc_cmd_t   cmd;
  } jasc_st_t;

  jasc_st_t s_q;
  jasc_st_t s_d;

  logic               auto_s;
  logic               cw_req;
  logic               ccw_req;
  logic               fast_req;
  logic               dir_ok;
  logic [15:0]        max_cur;
  logic [15:0]        jog_ilim;
  logic [15:0]        spd_lim;
  logic [15:0]        cur_lim;
  logic [15:0]        spd_fs;
  logic [15:0]        cur_fs;
  logic signed [15:0] jog_mag;
  logic signed [15:0] jog_spd;
  logic signed [15:0] dev_spd;
  logic signed [15:0] dev_cur;
  logic signed [15:0] auto_spd;
  logic signed [15:0] auto_cur;

  // ==========================================================================
  // Derived limits and requests
  // ==========================================================================
  // Pins are read only from the second synchroniser stage; the register bits act as the
  // software and handheld jog buttons and are simply ORed with the pins.
  assign auto_s   = s_q.pin_s2[PIN_AUTO];
  assign cw_req   = s_q.pin_s2[PIN_CW] | s_q.ctrl[CTRL_JOG_CW];
  assign ccw_req  = s_q.pin_s2[PIN_CCW] | s_q.ctrl[CTRL_JOG_CCW];
  assign fast_req = s_q.pin_s2[PIN_FAST] | s_q.ctrl[CTRL_JOG_FAST];
  assign dir_ok   = cw_req ^ ccw_req;
  assign max_cur  = min_u(s_q.cfg.mot_ipk, s_q.cfg.amp_ipk);
  assign jog_ilim = min_u(s_q.cfg.jog_ilim, max_cur);
  assign spd_lim  = min_u(s_q.cfg.spd_lim, s_q.cfg.top_spd);
  assign cur_lim  = min_u(s_q.cfg.cur_lim, max_cur);
  assign spd_fs   = min_u(s_q.cfg.spd_fs, s_q.cfg.top_spd);
  assign cur_fs   = min_u(s_q.cfg.cur_fs, max_cur);
  assign jog_mag  = fast_req ? s_q.cfg.jog_fast : s_q.cfg.jog_slow;
  // A counter-clockwise request negates the signed setting, so a negative setting reverses both.
  assign jog_spd  = clamp_s(cw_req ? sx(jog_mag) : -sx(jog_mag), s_q.cfg.top_spd);
  assign dev_spd  = clamp_s(sx(i_dev_value), spd_lim);
  assign dev_cur  = clamp_s(sx(i_dev_value), cur_lim);

  // ==========================================================================
  // Analog scaling
  // ==========================================================================
  // The converter word is taken fresh every clock with no filtering.
  jasc_scale u_spd_scale (
    .i_sample (i_adc),
    .i_full   (spd_fs),
    .i_lim    (spd_lim),
    .o_value  (auto_spd)
  );

  jasc_scale u_cur_scale (
    .i_sample (i_adc),
    .i_full   (cur_fs),
    .i_lim    (cur_lim),
    .o_value  (auto_cur)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Bus, synchronisers and mode sequencer all update one copy of the state.
  always_comb begin
    s_d        = s_q;
    s_d.pin_s1 = i_pins;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.rdata  = 16'h0000;
    if (i_bus.wr) begin
      case (i_bus.addr)
        A_CTRL:     s_d.ctrl         = i_bus.wdata[3:0];
        A_JOG_SLOW: s_d.cfg.jog_slow = i_bus.wdata;
        A_JOG_FAST: s_d.cfg.jog_fast = i_bus.wdata;
        A_JOG_ILIM: s_d.cfg.jog_ilim = i_bus.wdata;
        A_MOT_IPK:  s_d.cfg.mot_ipk  = i_bus.wdata;
        A_AMP_IPK:  s_d.cfg.amp_ipk  = i_bus.wdata;
        A_TOP_SPD:  s_d.cfg.top_spd  = i_bus.wdata;
        A_SPD_FS:   s_d.cfg.spd_fs   = i_bus.wdata;
        A_CUR_FS:   s_d.cfg.cur_fs   = i_bus.wdata;
        A_SPD_LIM:  s_d.cfg.spd_lim  = i_bus.wdata;
        A_CUR_LIM:  s_d.cfg.cur_lim  = i_bus.wdata;
        default: begin
        end
      endcase
    end
    if (i_bus.rd) begin
      case (i_bus.addr)
        A_CTRL:     s_d.rdata = {12'h000, s_q.ctrl};
        A_JOG_SLOW: s_d.rdata = s_q.cfg.jog_slow;
        A_JOG_FAST: s_d.rdata = s_q.cfg.jog_fast;
        A_JOG_ILIM: s_d.rdata = s_q.cfg.jog_ilim;
        A_MOT_IPK:  s_d.rdata = s_q.cfg.mot_ipk;
        A_AMP_IPK:  s_d.rdata = s_q.cfg.amp_ipk;
        A_TOP_SPD:  s_d.rdata = s_q.cfg.top_spd;
        A_SPD_FS:   s_d.rdata = s_q.cfg.spd_fs;
        A_CUR_FS:   s_d.rdata = s_q.cfg.cur_fs;
        A_SPD_LIM:  s_d.rdata = s_q.cfg.spd_lim;
        A_CUR_LIM:  s_d.rdata = s_q.cfg.cur_lim;
        A_STATUS:   s_d.rdata = {9'h000, auto_s, s_q.cmd.current_ctrl, s_q.cmd.speed_ctrl, s_q.state};
        default:    s_d.rdata = 16'h0000;
      endcase
    end
    // Safe default: speed control at zero speed with the full current envelope.
    s_d.cmd.speed_ctrl   = 1'b1;
    s_d.cmd.current_ctrl = 1'b0;
    s_d.cmd.speed        = 16'sh0000;
    s_d.cmd.current      = 16'sh0000;
    s_d.cmd.ilim         = max_cur;
    case (s_q.state)
      JASC_STOP: begin
        // The hold time runs first, then the motor must really stand before the new mode is taken.
        if (s_q.stop_cnt != 8'h00) begin
          s_d.stop_cnt = s_q.stop_cnt - 8'h01;
        end else if (i_standstill) begin
          s_d.state = auto_s ? JASC_AUTO : JASC_MAN;
        end
      end
      JASC_MAN: begin
        s_d.cmd.ilim = jog_ilim;
        if (auto_s) begin
          s_d.state    = JASC_STOP;
          s_d.stop_cnt = STOP_LOAD;
        end else if (dir_ok && i_standstill && !i_fault) begin
          s_d.state = JASC_JOG;
        end
      end
      JASC_JOG: begin
        s_d.cmd.ilim = jog_ilim;
        if (auto_s) begin
          s_d.state    = JASC_STOP;
          s_d.stop_cnt = STOP_LOAD;
        end else if (!dir_ok || i_fault) begin
          s_d.state = JASC_MAN;
        end else begin
          s_d.cmd.speed = jog_spd;
        end
      end
      JASC_AUTO: begin
        s_d.cmd.ilim = cur_lim;
        if (!auto_s) begin
          s_d.state    = JASC_STOP;
          s_d.stop_cnt = STOP_LOAD;
        end else if (s_q.ctrl[CTRL_AUTO_CUR]) begin
          // Speed and current selection may change here without a stop.
          s_d.cmd.speed_ctrl   = 1'b0;
          s_d.cmd.current_ctrl = 1'b1;
          if (i_amp_en) begin
            s_d.cmd.current = i_dev_active ? dev_cur : auto_cur;
          end
        end else if (i_amp_en) begin
          s_d.cmd.speed = i_dev_active ? dev_spd : auto_spd;
        end
      end
      default: begin
        s_d.state    = JASC_STOP;
        s_d.stop_cnt = STOP_LOAD;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Reset lands in the stop state so a live auto select is only acted on after a standstill.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q          <= '0;
      s_q.ctrl     <= RST_CTRL;
      s_q.cfg      <= CFG_RST;
      s_q.state    <= JASC_STOP;
      s_q.stop_cnt <= STOP_LOAD;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_cmd   = s_q.cmd;
  assign o_state = s_q.state;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  // A jog may only begin from manual standby with the motor at rest and no fault.
  a_jog_start_cond: assert property (
    (s_q.state == JASC_JOG) && ($past(s_q.state) == JASC_MAN) |-> $past(i_standstill && !i_fault))
    else $error("jog started while moving or faulted");

  // Opposing requests stop the motor; a pending mode change takes precedence over them.
  a_both_dir_zero: assert property (
    (s_q.state == JASC_JOG) && cw_req && ccw_req && !auto_s
    |=> (o_cmd.speed == 16'sh0000) && (s_q.state == JASC_MAN))
    else $error("both jog directions did not give zero speed");

  a_manual_speed: assert property (
    (s_q.state == JASC_MAN) || (s_q.state == JASC_JOG) |=> o_cmd.speed_ctrl && !o_cmd.current_ctrl)
    else $error("manual mode not under speed control");

  a_analog_auto_only: assert property (o_cmd.current_ctrl |-> $past(s_q.state) == JASC_AUTO)
    else $error("analog control outside automatic mode");

  a_jog_current_cap: assert property (
    $past(s_q.state) == JASC_JOG
    |-> (o_cmd.ilim <= $past(s_q.cfg.mot_ipk)) && (o_cmd.ilim <= $past(s_q.cfg.amp_ipk)))
    else $error("jog current limit above maximum current");

  a_mode_change_stop: assert property (
    (s_q.state == JASC_MAN) && auto_s |=> (s_q.state == JASC_STOP) ##1 (o_cmd.speed == 16'sh0000))
    else $error("mode change without stop");

  a_stop_hold_time: assert property (
    (s_q.state == JASC_STOP) && (s_q.stop_cnt != 8'h00) |=> s_q.state == JASC_STOP)
    else $error("stop left before hold time");

  // The stop state commands nothing, whatever the setpoint inputs do meanwhile.
  a_stop_zero_cmd: assert property (
    $past(s_q.state) == JASC_STOP |-> (o_cmd.speed == 16'sh0000) && (o_cmd.current == 16'sh0000))
    else $error("motor commanded during mode change stop");

  a_auto_follow: assert property (
    (s_q.state == JASC_AUTO) && auto_s && i_amp_en && !i_dev_active && !s_q.ctrl[CTRL_AUTO_CUR]
    |=> o_cmd.speed == $past(auto_spd))
    else $error("speed does not follow analog setpoint");

  // Automatic speed commands never exceed the configured speed limit in magnitude.
  a_auto_speed_cap: assert property (
    $past(s_q.state) == JASC_AUTO
    |-> (o_cmd.speed[15] ? -sx(o_cmd.speed) : sx(o_cmd.speed)) <= $signed({2'b00, $past(s_q.cfg.spd_lim)}))
    else $error("automatic speed above speed limit");

  a_jog_speed_cap: assert property (
    (s_q.state == JASC_JOG) && dir_ok && !auto_s && !i_fault
    |=> (sx(o_cmd.speed) <= sx($signed($past(s_q.cfg.top_spd)))) || $past(s_q.cfg.top_spd[15]))
    else $error("jog speed above top speed");

  // With a non-negative setting the sign of the command follows the requested direction.
  a_jog_cw_dir: assert property (
    (s_q.state == JASC_JOG) && cw_req && !ccw_req && !auto_s && !i_fault && !jog_mag[15]
    |=> !o_cmd.speed[15])
    else $error("clockwise jog ran counter-clockwise");

  a_jog_ccw_dir: assert property (
    (s_q.state == JASC_JOG) && ccw_req && !cw_req && !auto_s && !i_fault && !jog_mag[15]
    |=> o_cmd.speed[15] || (o_cmd.speed == 16'sh0000))
    else $error("counter-clockwise jog ran clockwise");

  // An in-range setting reaches the motor unchanged in magnitude, chosen by the speed select.
  a_jog_slow_pick: assert property (
    (s_q.state == JASC_JOG) && cw_req && !ccw_req && !fast_req && !auto_s && !i_fault
    && !s_q.cfg.jog_slow[15] && (s_q.cfg.jog_slow <= s_q.cfg.top_spd)
    |=> o_cmd.speed == $past(s_q.cfg.jog_slow))
    else $error("slow jog speed not applied");

  a_jog_fast_pick: assert property (
    (s_q.state == JASC_JOG) && ccw_req && !cw_req && fast_req && !auto_s && !i_fault
    && !s_q.cfg.jog_fast[15] && (s_q.cfg.jog_fast <= s_q.cfg.top_spd)
    |=> o_cmd.speed == 16'h0000 - $past(s_q.cfg.jog_fast))
    else $error("fast jog speed not applied");

  a_read_ctrl: assert property (
    i_bus.rd && (i_bus.addr == A_CTRL) |=> o_rdata == {12'h000, $past(s_q.ctrl)})
    else $error("control register read back wrong");

endmodule
